// [shared/swps_params.svh]
// Register map, field positions, reset values and encodings of the sleep-wake sequencer.
`ifndef SWPS_PARAMS_SVH
`define SWPS_PARAMS_SVH
`define SWPS_OFF_CTRL       8'h00
`define SWPS_OFF_WAKE_LO    8'h04
`define SWPS_OFF_WAKE_HI    8'h08
`define SWPS_OFF_SLEEP_CFG  8'h0c
`define SWPS_OFF_WAKE1_CFG  8'h10
`define SWPS_OFF_WAKE2_CFG  8'h14
`define SWPS_CTRL_SLEEP_GO  1
`define SWPS_CTRL_PIN_EN    2
`define SWPS_CTRL_PIN_HIGH  3
`define SWPS_CTRL_TIMER_EN  4
`define SWPS_CTRL_WIDE_CMP  5
`define SWPS_CTRL_MASK      32'h0000003e
`define SWPS_CTRL_RESET     32'h00000008
`define SWPS_CFG_DWELL_HI   20
`define SWPS_CFG_DWELL_LO   16
`define SWPS_CFG_CLK_OFF    14
`define SWPS_CFG_ANA_PFM    9
`define SWPS_CFG_CORE_PFM   8
`define SWPS_CFG_IO_EN      5
`define SWPS_CFG_PLL_EN     4
`define SWPS_CFG_ANA_EN     1
`define SWPS_CFG_CORE_EN    0
`define SWPS_CFG_WMASK      32'h001f4331
`define SWPS_SLEEP_RESET    32'h00100000
`define SWPS_WAKE1_RESET    32'h00100020
`define SWPS_WAKE2_RESET    32'h00100033
`define SWPS_RUN_CFG        32'h00000033
`endif

// [shared/swps_pkg.sv]
// Types shared by the sleep-wake sequencer.
package swps_pkg;
   typedef enum logic [3:0] {
      swps_running = 4'h1,
      swps_sleep   = 4'h2,
      swps_wake1   = 4'h4,
      swps_wake2   = 4'h8
   } swps_state_type;
endpackage

// [logic/swps_sequencer.sv]
// Sleep and wake sequencer with its register file and regulator controls.
`timescale 1ns/1ns
`include "swps_params.svh"
module swps_sequencer #(
   parameter int DWELL_W = 32
) (
   // Clock and reset.
   input  wire logic        core_clk,
   input  wire logic        reset,
   // Register port.
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   output logic      [31:0] reg_rdata,
   // Wake sources.
   input  wire logic [63:0] rtc_count,
   input  wire logic        wake_pin,
   // Supply good indications.
   input  wire logic        core_good,
   input  wire logic        ana_good,
   input  wire logic        io_good,
   input  wire logic        pll_good,
   // Supply and clock controls, and the sequence state.
   output logic             core_switching_regulator,
   output logic             analogue_switching_regulator,
   output logic             io_supply_output,
   output logic             pll_linear_regulator,
   output logic             core_pfm,
   output logic             ana_pfm,
   output logic             tile_clk_off,
   output swps_pkg::swps_state_type seq_state
);

   logic [31:0]     ctrl;
   logic [31:0]     wake_lo;
   logic [31:0]     wake_hi;
   logic [31:0]     cfg [3];
   logic [DWELL_W-1:0] dwell;
   logic [31:0]     cur_cfg;
   logic [31:0]     next_cfg;
   logic [DWELL_W-1:0] dwell_limit;
   logic            dwell_done;
   logic            timer_hit;
   logic            pin_hit;
   logic            supplies_good;
   logic            start_sleep;
   swps_pkg::swps_state_type next_state;

   // Settings of the state currently held.
   always_comb begin
      case (seq_state)
         swps_pkg::swps_sleep: cur_cfg = cfg[0];
         swps_pkg::swps_wake1: cur_cfg = cfg[1];
         swps_pkg::swps_wake2: cur_cfg = cfg[2];
         default:              cur_cfg = `SWPS_RUN_CFG;
      endcase
   end

   // Dwell limit is two to the power of the field, minus one, as a terminal count.
   assign dwell_limit = DWELL_W'((64'h1 << cur_cfg[`SWPS_CFG_DWELL_HI:`SWPS_CFG_DWELL_LO])
                                 - 64'h1);
   assign dwell_done  = (dwell >= dwell_limit);

   // Wake conditions; the upper word is only consulted with wide compare while asleep.
   always_comb begin
      if (ctrl[`SWPS_CTRL_WIDE_CMP]) begin
         timer_hit = ({rtc_count[63:32], rtc_count[31:0]} >= {wake_hi, wake_lo});
      end else begin
         timer_hit = (rtc_count[31:0] >= wake_lo);
      end
   end
   assign pin_hit = ctrl[`SWPS_CTRL_PIN_EN] &&
                    (wake_pin == ctrl[`SWPS_CTRL_PIN_HIGH]);

   // Only supplies enabled in the current state need to be good.
   assign supplies_good = (!cur_cfg[`SWPS_CFG_CORE_EN] || core_good) &&
                          (!cur_cfg[`SWPS_CFG_ANA_EN]  || ana_good) &&
                          (!cur_cfg[`SWPS_CFG_IO_EN]   || io_good) &&
                          (!cur_cfg[`SWPS_CFG_PLL_EN]  || pll_good);

   assign start_sleep = ctrl[`SWPS_CTRL_SLEEP_GO] && (seq_state == swps_pkg::swps_running);

   // Next state of the sequence.
   always_comb begin
      next_state = seq_state;
      case (seq_state)
         swps_pkg::swps_running: begin
            if (start_sleep) begin
               next_state = swps_pkg::swps_sleep;
            end
         end
         swps_pkg::swps_sleep: begin
            if (dwell_done && ((ctrl[`SWPS_CTRL_TIMER_EN] && timer_hit) || pin_hit)) begin
               next_state = swps_pkg::swps_wake1;
            end
         end
         swps_pkg::swps_wake1: begin
            if (dwell_done && supplies_good) begin
               next_state = swps_pkg::swps_wake2;
            end
         end
         swps_pkg::swps_wake2: begin
            if (dwell_done && supplies_good) begin
               next_state = swps_pkg::swps_running;
            end
         end
         default: next_state = swps_pkg::swps_running;
      endcase
   end

   // State register.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         seq_state <= swps_pkg::swps_running;
      end else begin
         seq_state <= next_state;
      end
   end

   // Dwell counter restarts on every state change and saturates.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         dwell <= '0;
      end else if (next_state != seq_state) begin
         dwell <= '0;
      end else if (!dwell_done) begin
         dwell <= dwell + DWELL_W'(1);
      end
   end

   // General control; the sleep start bit clears itself once the sequence begins.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ctrl <= `SWPS_CTRL_RESET;
      end else if (reg_write && reg_addr == `SWPS_OFF_CTRL) begin
         ctrl <= reg_wdata & `SWPS_CTRL_MASK;
         if (start_sleep) begin
            ctrl[`SWPS_CTRL_SLEEP_GO] <= 1'b0;
         end
      end else if (start_sleep) begin
         ctrl[`SWPS_CTRL_SLEEP_GO] <= 1'b0;
      end
   end

   // Wake time words.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         wake_lo <= 32'h00000000;
         wake_hi <= 32'h00000000;
      end else if (reg_write) begin
         if (reg_addr == `SWPS_OFF_WAKE_LO) begin
            wake_lo <= reg_wdata;
         end
         if (reg_addr == `SWPS_OFF_WAKE_HI) begin
            wake_hi <= reg_wdata;
         end
      end
   end

   // Per-state supply configuration; the analogue enable bit keeps its reset value.
   for (genvar i = 0; i < 3; i++) begin : g_cfg
      // Reset value is fixed at elaboration so the asynchronous branch loads a constant.
      localparam logic [31:0] CFG_RESET = (i == 0) ? `SWPS_SLEEP_RESET :
                                          (i == 1) ? `SWPS_WAKE1_RESET : `SWPS_WAKE2_RESET;
      always_ff @(posedge core_clk or posedge reset) begin
         if (reset) begin
            cfg[i] <= CFG_RESET;
         end else if (reg_write && reg_addr == 8'(`SWPS_OFF_SLEEP_CFG + 4 * i)) begin
            cfg[i] <= (reg_wdata & `SWPS_CFG_WMASK) |
                      (cfg[i] & ~`SWPS_CFG_WMASK);
         end
      end
   end

   // Read data, registered; unmapped offsets read zero.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_read) begin
         case (reg_addr)
            `SWPS_OFF_CTRL:      reg_rdata <= ctrl;
            `SWPS_OFF_WAKE_LO:   reg_rdata <= wake_lo;
            `SWPS_OFF_WAKE_HI:   reg_rdata <= wake_hi;
            `SWPS_OFF_SLEEP_CFG: reg_rdata <= cfg[0];
            `SWPS_OFF_WAKE1_CFG: reg_rdata <= cfg[1];
            `SWPS_OFF_WAKE2_CFG: reg_rdata <= cfg[2];
            default:             reg_rdata <= 32'h00000000;
         endcase
      end
   end

   // Supply and clock controls follow the settings of the state being entered.
   always_comb begin
      case (next_state)
         swps_pkg::swps_sleep: next_cfg = cfg[0];
         swps_pkg::swps_wake1: next_cfg = cfg[1];
         swps_pkg::swps_wake2: next_cfg = cfg[2];
         default:              next_cfg = `SWPS_RUN_CFG;
      endcase
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         core_switching_regulator     <= 1'b1;
         analogue_switching_regulator <= 1'b1;
         io_supply_output             <= 1'b1;
         pll_linear_regulator         <= 1'b1;
         core_pfm                     <= 1'b0;
         ana_pfm                      <= 1'b0;
         tile_clk_off                 <= 1'b0;
      end else begin
         core_switching_regulator     <= next_cfg[`SWPS_CFG_CORE_EN];
         analogue_switching_regulator <= next_cfg[`SWPS_CFG_ANA_EN];
         io_supply_output             <= next_cfg[`SWPS_CFG_IO_EN];
         pll_linear_regulator         <= next_cfg[`SWPS_CFG_PLL_EN];
         core_pfm                     <= next_cfg[`SWPS_CFG_CORE_PFM];
         ana_pfm                      <= next_cfg[`SWPS_CFG_ANA_PFM];
         tile_clk_off                 <= next_cfg[`SWPS_CFG_CLK_OFF];
      end
   end

   // The sleep dwell is never cut short by a wake condition.
   sleep_dwell_a: assert property (@(posedge core_clk) disable iff (reset)
      (seq_state == swps_pkg::swps_sleep && !dwell_done) |=> seq_state != swps_pkg::swps_wake1)
      else $error("sleep left before its dwell expired");

   // The first waking state only advances with its supplies good.
   wake_good_a: assert property (@(posedge core_clk) disable iff (reset)
      (seq_state == swps_pkg::swps_wake1 && !supplies_good) |=> seq_state == swps_pkg::swps_wake1)
      else $error("first waking state left with a supply not good");

   // The clock gate tracks the state's setting.
   clock_gate_a: assert property (@(posedge core_clk) disable iff (reset)
      tile_clk_off == cur_cfg[`SWPS_CFG_CLK_OFF])
      else $error("tile clock gate disagrees with state setting");

   // The IO supply tracks the state's setting.
   io_supply_a: assert property (@(posedge core_clk) disable iff (reset)
      io_supply_output == cur_cfg[`SWPS_CFG_IO_EN])
      else $error("io supply disagrees with state setting");

   // The core regulator tracks the state's setting.
   core_reg_a: assert property (@(posedge core_clk) disable iff (reset)
      core_switching_regulator == cur_cfg[`SWPS_CFG_CORE_EN])
      else $error("core regulator disagrees with state setting");

   // The analogue regulator mode tracks the state's setting.
   ana_pfm_a: assert property (@(posedge core_clk) disable iff (reset)
      ana_pfm == cur_cfg[`SWPS_CFG_ANA_PFM])
      else $error("analogue regulator mode disagrees with state setting");

   // The core regulator mode tracks the state's setting.
   core_pfm_a: assert property (@(posedge core_clk) disable iff (reset)
      core_pfm == cur_cfg[`SWPS_CFG_CORE_PFM])
      else $error("core regulator mode disagrees with state setting");

   // The PLL linear regulator tracks the state's setting.
   pll_reg_a: assert property (@(posedge core_clk) disable iff (reset)
      pll_linear_regulator == cur_cfg[`SWPS_CFG_PLL_EN])
      else $error("pll regulator disagrees with state setting");

   // The second waking state only advances with its supplies good.
   wake2_good_a: assert property (@(posedge core_clk) disable iff (reset)
      (seq_state == swps_pkg::swps_wake2 && !supplies_good) |=> seq_state == swps_pkg::swps_wake2)
      else $error("second waking state left with a supply not good");

   // Order of the sequence.
   seq_order_a: assert property (@(posedge core_clk) disable iff (reset)
      (seq_state == swps_pkg::swps_running && $past(seq_state) != swps_pkg::swps_running)
      |-> $past(seq_state) == swps_pkg::swps_wake2)
      else $error("running state entered out of order");

   // The start bit clears on the same edge that the sleep state is entered.
   sleep_start_a: assert property (@(posedge core_clk) disable iff (reset)
      start_sleep |=> (!ctrl[`SWPS_CTRL_SLEEP_GO] && seq_state == swps_pkg::swps_sleep))
      else $error("sleep start not taken or not cleared");

   // Analogue enable bit of the sleep and second waking settings never changes under software.
   ana_ro_a: assert property (@(posedge core_clk) disable iff (reset)
      $stable(cfg[0][`SWPS_CFG_ANA_EN]) && $stable(cfg[2][`SWPS_CFG_ANA_EN]))
      else $error("read-only analogue enable bit changed");

endmodule

// [tb/swps_supply_model.sv]
// Model of the regulators that report good after staying enabled for a while.
`timescale 1ns/1ns
module swps_supply_model #(
   parameter int DELAY = 3
) (
   // Clock and reset.
   input  wire logic       core_clk,
   input  wire logic       reset,
   // Enables in the order core, analogue, io, pll, and a stall for the io supply.
   input  wire logic [3:0] enable,
   input  wire logic       hold_io,
   // Good indications in the same order.
   output logic      [3:0] good
);
   int unsigned age [4];

   // Each supply counts its enabled cycles and restarts when switched off.
   always_ff @(posedge core_clk or posedge reset) begin
      for (int k = 0; k < 4; k++) begin
         if (reset || !enable[k]) begin
            age[k] <= 0;
         end else if (age[k] < DELAY) begin
            age[k] <= age[k] + 1;
         end
      end
   end

   // A supply is good once settled; the io supply can be held back on request.
   always_comb begin
      for (int k = 0; k < 4; k++) begin
         good[k] = (age[k] == DELAY) && !(k == 2 && hold_io);
      end
   end
endmodule

// [tb/swps_sequencer_tb.sv]
// Self-checking bench for the sleep and wake sequencer.
`timescale 1ns/1ns
module swps_sequencer_tb;
   typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} swps_row_type;
   logic                     core_clk = 1'b0;
   logic                     reset = 1'b1;
   logic                     reg_write = 1'b0;
   logic                     reg_read = 1'b0;
   logic [7:0]               reg_addr = 8'h00;
   logic [31:0]              reg_wdata = 32'h0;
   logic [31:0]              reg_rdata;
   logic [63:0]              rtc_count = 64'h0;
   logic                     wake_pin = 1'b0;
   logic                     hold_io = 1'b0;
   logic [3:0]               good;
   logic                     core_en, ana_en, io_en, pll_en, core_pfm, ana_pfm, tile_clk_off;
   swps_pkg::swps_state_type seq_state;
   int                       err_count = 0;
   int                       checked = 0;
   logic [31:0]              q;
   wire [6:0] outs = {tile_clk_off, ana_pfm, core_pfm, pll_en, io_en, ana_en, core_en};
   // Writes with the value each should read back, unmapped offset last.
   swps_row_type rows [7] = '{'{8'h04, 32'hffffffff, 32'hffffffff},
      '{8'h08, 32'h12345678, 32'h12345678}, '{8'h0c, 32'hffffffff, 32'h001f4331},
      '{8'h10, 32'hffffffff, 32'h001f4331},
      '{8'h14, 32'hffffffff, 32'h001f4333}, '{8'h00, 32'h0000003c, 32'h0000003c},
      '{8'h1c, 32'hffffffff, 32'h00000000}};
   // Offsets with their values after reset.
   swps_row_type rst [6] = '{'{8'h00, 32'h0, 32'h8}, '{8'h04, 32'h0, 32'h0},
      '{8'h08, 32'h0, 32'h0}, '{8'h0c, 32'h0, 32'h00100000},
      '{8'h10, 32'h0, 32'h00100020}, '{8'h14, 32'h0, 32'h00100033}};

   // The design and the supplies on its far side.
   swps_sequencer #(.DWELL_W(32)) u_swps_sequencer (.core_clk(core_clk), .reset(reset),
      .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rtc_count(rtc_count),
      .wake_pin(wake_pin), .core_good(good[0]), .ana_good(good[1]), .io_good(good[2]),
      .pll_good(good[3]), .core_switching_regulator(core_en),
      .analogue_switching_regulator(ana_en), .io_supply_output(io_en),
      .pll_linear_regulator(pll_en), .core_pfm(core_pfm), .ana_pfm(ana_pfm),
      .tile_clk_off(tile_clk_off), .seq_state(seq_state));
   swps_supply_model #(.DELAY(3)) u_swps_supply_model (.core_clk(core_clk), .reset(reset),
      .enable({pll_en, io_en, ana_en, core_en}), .hold_io(hold_io), .good(good));

   // Clock of 10 ns period.
   always #5 core_clk = ~core_clk;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_write <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      @(posedge core_clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_read <= 1'b0;
      #1 r = reg_rdata;
   endtask

   task automatic wait_for(input swps_pkg::swps_state_type s);
      int i;
      for (i = 0; i < 400 && seq_state !== s; i++) begin
         @(posedge core_clk);
         #1;
      end
      if (seq_state !== s) begin
         err_count++;
         results();
      end
   endtask

   task automatic sleep_round(input logic [31:0] c, input logic [63:0] r0, input logic [63:0] r1,
                              input logic p0, input logic p1, input int hold);
      int n;
      int lim;
      lim = (hold > 4) ? hold : 4;
      @(posedge core_clk);
      rtc_count <= r0;
      wake_pin <= p0;
      wr(8'h00, c | 32'h2);
      wait_for(swps_pkg::swps_sleep);
      chk({25'h0, outs}, 32'h70);
      for (n = 1; n < 300 && seq_state === swps_pkg::swps_sleep; n++) begin
         @(posedge core_clk);
         if (n == hold) begin
            rtc_count <= r1;
            wake_pin <= p1;
         end
         #1;
      end
      chk({31'h0, (n >= lim + 1) && (n <= lim + 5)}, 32'h1);
      chk({28'h0, seq_state}, 32'h4);
      chk({25'h0, outs}, 32'h1c);
      @(posedge core_clk);
      hold_io <= 1'b1;
      repeat (12) @(posedge core_clk);
      #1 chk({28'h0, seq_state}, 32'h4);
      @(posedge core_clk);
      hold_io <= 1'b0;
      wait_for(swps_pkg::swps_wake2);
      chk({25'h0, outs}, 32'h03);
      wait_for(swps_pkg::swps_running);
      chk({25'h0, outs}, 32'h0f);
      rd(8'h00, q);
      chk(q, c & 32'h3c);
      $display("Sleep round with control %h done", c);
   endtask

   task automatic results();
      $display("Checks made %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Main sequence: register rows, wake rounds, then a reset in mid-sleep.
   initial begin
      repeat (20) @(posedge core_clk);
      reset <= 1'b0;
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, q);
         chk(q, rows[i].e);
      end
      $display("Register rows done");
      wr(8'h0c, 32'h00024300);
      wr(8'h10, 32'h00010130);
      wr(8'h14, 32'h00000001);
      wr(8'h04, 32'd100);
      wr(8'h08, 32'h1);
      sleep_round(32'h12, 64'd50, 64'd100, 1'b0, 1'b0, 10);
      sleep_round(32'h32, 64'h0_ffffffff, 64'h1_00000064, 1'b0, 1'b0, 10);
      sleep_round(32'h06, 64'd200, 64'd200, 1'b1, 1'b0, 10);
      sleep_round(32'h0e, 64'h0, 64'h0, 1'b0, 1'b1, 10);
      sleep_round(32'h12, 64'd100, 64'd100, 1'b0, 1'b0, 0);
      wr(8'h00, 32'h2);
      wait_for(swps_pkg::swps_sleep);
      @(posedge core_clk);
      reset <= 1'b1;
      repeat (20) @(posedge core_clk);
      #1 chk({21'h0, outs, 4'h0} | {28'h0, seq_state}, 32'h0f1);
      @(posedge core_clk);
      reset <= 1'b0;
      foreach (rst[i]) begin
         rd(rst[i].a, q);
         chk(q, rst[i].e);
      end
      $display("Reset checks done");
      results();
   end
endmodule
